//--- hdl/hpl_map.vh
// register map, field layout and constants of the line-lock and clamp-gain block
`ifndef HPL_MAP_VH
`define HPL_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define HPL_ADDR_RSVD_A      8'h1E
`define HPL_ADDR_RUN_COUNTS  8'h28
`define HPL_ADDR_THRESHOLD   8'h29
`define HPL_ADDR_CLAMP_GAINS 8'h2A
`define HPL_ADDR_STATUS      8'h40

// ****************************************
// reset values
// ****************************************
`define HPL_RST_RSVD_A       8'h66
`define HPL_RST_RUN_COUNTS   8'h82
`define HPL_RST_THRESHOLD    8'h55
`define HPL_RST_CLAMP_GAINS  8'h82
`define HPL_RD_UNMAPPED      8'h00

// ****************************************
// field positions
// ****************************************
`define HPL_UNLOCK_CNT_MSB   7
`define HPL_UNLOCK_CNT_LSB   4
`define HPL_LOCK_CNT_MSB     3
`define HPL_LOCK_CNT_LSB     0
`define HPL_THRESH_MSB       3
`define HPL_THRESH_LSB       0
`define HPL_PROP_MSB         7
`define HPL_PROP_LSB         6
`define HPL_DER_MSB          5
`define HPL_DER_LSB          4
`define HPL_INT_MSB          2
`define HPL_INT_LSB          0

// ****************************************
// scaling: run count x4, threshold x8
// ****************************************
`define HPL_RUN_SHIFT        2
`define HPL_THRESH_SHIFT     3

// ****************************************
// proportional shifts (divide by 64,32,16,8)
// ****************************************
`define HPL_P_SHIFT_00       4'd6
`define HPL_P_SHIFT_01       4'd5
`define HPL_P_SHIFT_10       4'd4
`define HPL_P_SHIFT_11       4'd3

// ****************************************
// derivative shifts (1, 1/2, 1/4, off)
// ****************************************
`define HPL_D_SHIFT_00       4'd0
`define HPL_D_SHIFT_01       4'd1
`define HPL_D_SHIFT_10       4'd2
`define HPL_D_OFF            2'h3

// ****************************************
// integral reciprocals, 2^16 / divisor
// divisors 64,128,256,512,1024,2048,4096,5192
// ****************************************
`define HPL_I_FRAC           16
`define HPL_I_RECIP_0        12'h400
`define HPL_I_RECIP_1        12'h200
`define HPL_I_RECIP_2        12'h100
`define HPL_I_RECIP_3        12'h080
`define HPL_I_RECIP_4        12'h040
`define HPL_I_RECIP_5        12'h020
`define HPL_I_RECIP_6        12'h010
`define HPL_I_RECIP_7        12'h00D

`endif

//--- hdl/hpl_lock_det.v
// consecutive-line lock detector of the line-locking pll
`timescale 1ns/10ps
`include "hpl_map.vh"

module hpl_lock_det (
   input  wire        i_mclk,
   input  wire        i_nrst,
   input  wire        i_line_strobe,
   input  wire [11:0] i_phase_err,
   input  wire [3:0]  i_lock_cnt,
   input  wire [3:0]  i_unlock_cnt,
   input  wire [3:0]  i_threshold,
   output reg         o_locked,
   output reg         o_lock_event
);

   reg  [5:0]  run_reg;
   reg  [5:0]  run_next;
   reg         locked_next;
   wire [11:0] thresh;
   wire [5:0]  lock_target;
   wire [5:0]  unlock_target;
   wire        bad_line;
   wire        good_line;
   wire        opposite;
   wire [5:0]  target;

   // ****************************************
   // line classification
   // ****************************************
   // equal to the threshold is neither good nor bad, so it breaks either run
   assign thresh        = {8'h00, i_threshold} << `HPL_THRESH_SHIFT;
   assign bad_line      = (i_phase_err > thresh);
   assign good_line     = (i_phase_err < thresh);
   assign lock_target   = {2'h0, i_lock_cnt} << `HPL_RUN_SHIFT;
   assign unlock_target = {2'h0, i_unlock_cnt} << `HPL_RUN_SHIFT;
   assign opposite      = o_locked ? bad_line : good_line;
   assign target        = o_locked ? unlock_target : lock_target;

   // run counting; a zero count field flips on the first opposite line
   always @* begin
      run_next    = run_reg;
      locked_next = o_locked;
      if (i_line_strobe) begin
         if (!opposite) begin
            run_next = 6'h00;
         end else if ((run_reg + 6'h01) >= target) begin
            run_next    = 6'h00;
            locked_next = !o_locked;
         end else begin
            run_next = run_reg + 6'h01;
         end
      end
   end

   // state registers
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_reg      <= 6'h00;
         o_locked     <= 1'b0;
         o_lock_event <= 1'b0;
      end else begin
         run_reg      <= run_next;
         o_locked     <= locked_next;
         o_lock_event <= (locked_next != o_locked);
      end
   end

endmodule // hpl_lock_det

//--- hdl/hpl_top.v
// line-lock detector registers and composite clamp pid regulator
`timescale 1ns/10ps
`include "hpl_map.vh"

module hpl_top (
   input  wire               i_mclk,
   input  wire               i_nrst,
   // register port from the chip's two-wire control slave
   input  wire [7:0]         i_reg_addr,
   input  wire [7:0]         i_reg_wdata,
   input  wire               i_reg_wr,
   input  wire               i_reg_rd,
   output reg  [7:0]         o_reg_rdata,
   output reg                o_reg_rvalid,
   // per-line phase error of the line-locking pll
   input  wire               i_line_strobe,
   input  wire [11:0]        i_phase_err,
   output wire               o_hlock,
   output wire               o_hlock_event,
   // per-line clamp level error
   input  wire               i_clamp_strobe,
   input  wire signed [9:0]  i_clamp_err,
   output reg  signed [19:0] o_clamp_ctrl,
   output reg                o_clamp_valid
);

   // ****************************************
   // register file
   // ****************************************
   reg  [7:0] rsvd_a_reg;
   reg  [7:0] run_counts_reg;
   reg  [7:0] threshold_reg;
   reg  [7:0] clamp_gains_reg;
   reg  [7:0] rdata_next;

   // ****************************************
   // clamp loop state
   // ****************************************
   reg  signed [9:0]  prev_err_reg;
   reg  signed [23:0] integ_reg;
   wire signed [23:0] integ_next;
   wire signed [10:0] diff;
   wire signed [10:0] p_term;
   wire signed [10:0] d_term;
   wire signed [35:0] i_prod;
   wire signed [19:0] i_term;
   wire signed [19:0] pid_sum;
   wire [1:0]         prop_code;
   wire [1:0]         der_code;
   wire [2:0]         int_code;

   // ****************************************
   // functions
   // ****************************************

   // arithmetic right shift used by the p and d terms
   function signed [10:0] hpl_ashr;
      input signed [10:0] val;
      input [3:0]         sh;
      begin
         hpl_ashr = val >>> sh;
      end
   endfunction

   // proportional code to shift
   function [3:0] hpl_p_shift;
      input [1:0] code;
      begin
         case (code)
            2'h0:    hpl_p_shift = `HPL_P_SHIFT_00;
            2'h1:    hpl_p_shift = `HPL_P_SHIFT_01;
            2'h2:    hpl_p_shift = `HPL_P_SHIFT_10;
            default: hpl_p_shift = `HPL_P_SHIFT_11;
         endcase
      end
   endfunction

   // derivative code to shift; the off code is handled by the caller
   function [3:0] hpl_d_shift;
      input [1:0] code;
      begin
         case (code)
            2'h0:    hpl_d_shift = `HPL_D_SHIFT_00;
            2'h1:    hpl_d_shift = `HPL_D_SHIFT_01;
            default: hpl_d_shift = `HPL_D_SHIFT_10;
         endcase
      end
   endfunction

   // integral code to reciprocal; multiply avoids a true divider
   function [11:0] hpl_i_recip;
      input [2:0] code;
      begin
         case (code)
            3'h0:    hpl_i_recip = `HPL_I_RECIP_0;
            3'h1:    hpl_i_recip = `HPL_I_RECIP_1;
            3'h2:    hpl_i_recip = `HPL_I_RECIP_2;
            3'h3:    hpl_i_recip = `HPL_I_RECIP_3;
            3'h4:    hpl_i_recip = `HPL_I_RECIP_4;
            3'h5:    hpl_i_recip = `HPL_I_RECIP_5;
            3'h6:    hpl_i_recip = `HPL_I_RECIP_6;
            default: hpl_i_recip = `HPL_I_RECIP_7;
         endcase
      end
   endfunction

   // ****************************************
   // register writes
   // ****************************************
   // reserved bits are stored as written; the host keeps them at their values
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rsvd_a_reg      <= `HPL_RST_RSVD_A;
         run_counts_reg  <= `HPL_RST_RUN_COUNTS;
         threshold_reg   <= `HPL_RST_THRESHOLD;
         clamp_gains_reg <= `HPL_RST_CLAMP_GAINS;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `HPL_ADDR_RSVD_A:      rsvd_a_reg      <= i_reg_wdata;
            `HPL_ADDR_RUN_COUNTS:  run_counts_reg  <= i_reg_wdata;
            `HPL_ADDR_THRESHOLD:   threshold_reg   <= i_reg_wdata;
            `HPL_ADDR_CLAMP_GAINS: clamp_gains_reg <= i_reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   // read mux; unmapped addresses answer zero
   always @* begin
      case (i_reg_addr)
         `HPL_ADDR_RSVD_A:      rdata_next = rsvd_a_reg;
         `HPL_ADDR_RUN_COUNTS:  rdata_next = run_counts_reg;
         `HPL_ADDR_THRESHOLD:   rdata_next = threshold_reg;
         `HPL_ADDR_CLAMP_GAINS: rdata_next = clamp_gains_reg;
         `HPL_ADDR_STATUS:      rdata_next = {7'h00, o_hlock};
         default:               rdata_next = `HPL_RD_UNMAPPED;
      endcase
   end

   // registered read answer, one cycle after the request
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_next;
         end
      end
   end

   // ****************************************
   // lock detector
   // ****************************************
   hpl_lock_det u_lock_det (
      .i_mclk        (i_mclk),
      .i_nrst        (i_nrst),
      .i_line_strobe (i_line_strobe),
      .i_phase_err   (i_phase_err),
      .i_lock_cnt    (run_counts_reg[`HPL_LOCK_CNT_MSB:`HPL_LOCK_CNT_LSB]),
      .i_unlock_cnt  (run_counts_reg[`HPL_UNLOCK_CNT_MSB:`HPL_UNLOCK_CNT_LSB]),
      .i_threshold   (threshold_reg[`HPL_THRESH_MSB:`HPL_THRESH_LSB]),
      .o_locked      (o_hlock),
      .o_lock_event  (o_hlock_event)
   );

   // ****************************************
   // clamp pid terms
   // ****************************************
   assign prop_code  = clamp_gains_reg[`HPL_PROP_MSB:`HPL_PROP_LSB];
   assign der_code   = clamp_gains_reg[`HPL_DER_MSB:`HPL_DER_LSB];
   assign int_code   = clamp_gains_reg[`HPL_INT_MSB:`HPL_INT_LSB];
   assign diff       = {i_clamp_err[9], i_clamp_err} - {prev_err_reg[9], prev_err_reg};
   assign p_term     = hpl_ashr({i_clamp_err[9], i_clamp_err}, hpl_p_shift(prop_code));
   assign d_term     = (der_code == `HPL_D_OFF) ? 11'sh000
                       : hpl_ashr(diff, hpl_d_shift(der_code));
   // accumulator is wide enough that it cannot wrap within any realistic field
   assign integ_next = integ_reg + {{14{i_clamp_err[9]}}, i_clamp_err};
   assign i_prod     = integ_next * $signed({1'b0, hpl_i_recip(int_code)});
   assign i_term     = i_prod[`HPL_I_FRAC+19:`HPL_I_FRAC];
   assign pid_sum    = i_term + {{9{p_term[10]}}, p_term} + {{9{d_term[10]}}, d_term};

   // loop state and output update once per clamp measurement
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         prev_err_reg  <= 10'sh000;
         integ_reg     <= 24'sh000000;
         o_clamp_ctrl  <= 20'sh00000;
         o_clamp_valid <= 1'b0;
      end else begin
         o_clamp_valid <= i_clamp_strobe;
         if (i_clamp_strobe) begin
            prev_err_reg <= i_clamp_err;
            integ_reg    <= integ_next;
            o_clamp_ctrl <= pid_sum;
         end
      end
   end

endmodule // hpl_top

//--- sim/hpl_top_sva.sv
// assertion checker bound to the line-lock and clamp-gain top
`timescale 1ns/10ps
module hpl_top_sva (
   input wire logic               i_mclk,
   input wire logic               i_nrst,
   input wire logic [7:0]         i_reg_addr,
   input wire logic [7:0]         i_reg_wdata,
   input wire logic               i_reg_wr,
   input wire logic               i_reg_rd,
   input wire logic [7:0]         o_reg_rdata,
   input wire logic               o_reg_rvalid,
   input wire logic               i_line_strobe,
   input wire logic [11:0]        i_phase_err,
   input wire logic               o_hlock,
   input wire logic               o_hlock_event,
   input wire logic               i_clamp_strobe,
   input wire logic signed [9:0]  i_clamp_err,
   input wire logic signed [19:0] o_clamp_ctrl,
   input wire logic               o_clamp_valid
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // ****************************************
   // lock state steps
   // ****************************************
   sequence s_flip;
      $changed(o_hlock);
   endsequence
   sequence s_one_pulse;
      o_hlock_event ##1 !o_hlock_event;
   endsequence
   a_flip_event_pulse: assert property (s_flip |-> s_one_pulse) else $error("lock change without one event pulse");
   a_flip_on_line: assert property (s_flip |-> $past(i_line_strobe)) else $error("lock changed without a line");
   a_event_cause: assert property ($stable(o_hlock) |-> !o_hlock_event) else $error("event without lock change");
   // ****************************************
   // register and clamp answers
   // ****************************************
   a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("read valid without read");
   a_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata)) else $error("read data moved");
   a_clamp_answer: assert property (i_clamp_strobe |=> o_clamp_valid) else $error("clamp not answered");
   a_clamp_cause: assert property (o_clamp_valid |-> $past(i_clamp_strobe)) else $error("clamp valid alone");
   a_ctrl_hold: assert property (!o_clamp_valid |-> $stable(o_clamp_ctrl)) else $error("clamp output moved");
endmodule // hpl_top_sva

bind hpl_top hpl_top_sva u_sva (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_line_strobe(i_line_strobe), .i_phase_err(i_phase_err), .o_hlock(o_hlock),
   .o_hlock_event(o_hlock_event), .i_clamp_strobe(i_clamp_strobe), .i_clamp_err(i_clamp_err),
   .o_clamp_ctrl(o_clamp_ctrl), .o_clamp_valid(o_clamp_valid)
);

//--- sim/hpl_video_src.sv
// behavioural source of per-line phase error and clamp error strobes
`timescale 1ns/10ps
module hpl_video_src (
   input  wire logic          i_mclk,
   output logic               o_line_strobe,
   output logic [11:0]        o_phase_err,
   output logic               o_clamp_strobe,
   output logic signed [9:0]  o_clamp_err
);
   // idle at time zero
   initial begin
      o_line_strobe = 1'b0;
      o_phase_err = 12'hFFF;
      o_clamp_strobe = 1'b0;
      o_clamp_err = 10'h3FF;
   end
   // n lines, gap idle cycles between; stale data is inverted so it never looks valid
   // back-to-back lines keep the strobe up; an edge passes first so a strobe just lowered is not raised again
   task automatic lines(input int n, input logic [11:0] err, input int gap);
      @(negedge i_mclk);
      for (int k = 0; k < n; k++) begin
         o_line_strobe = 1'b1;
         o_phase_err = err;
         @(negedge i_mclk);
         if (gap > 0) begin
            o_line_strobe = 1'b0;
            o_phase_err = ~err;
            repeat (gap) @(negedge i_mclk);
         end
      end
      o_line_strobe = 1'b0;
      o_phase_err = ~err;
   endtask
   // one clamp measurement
   task automatic clamp(input logic signed [9:0] e);
      o_clamp_strobe = 1'b1;
      o_clamp_err = e;
      @(negedge i_mclk);
      o_clamp_strobe = 1'b0;
      o_clamp_err = ~e;
   endtask
endmodule // hpl_video_src

//--- sim/hpl_top_test.sv
// self-checking bench for the line-lock and clamp-gain top
`timescale 1ns/10ps
module hpl_top_test;
   logic              i_mclk = 1'b0;
   logic              i_nrst = 1'b0;
   logic [7:0]        i_reg_addr = 8'h00;
   logic [7:0]        i_reg_wdata = 8'h00;
   logic              i_reg_wr = 1'b0;
   logic              i_reg_rd = 1'b0;
   wire  [7:0]        o_reg_rdata;
   wire               o_reg_rvalid, o_hlock, o_hlock_event, o_clamp_valid, ln_stb, cl_stb;
   wire  [11:0]       ph_err;
   wire signed [9:0]  cl_err;
   wire signed [19:0] o_clamp_ctrl;
   int                errors = 0;
   int                check_count = 0;
   int                acc = 0;
   int                prev = 0;
   int                e, exp_c;
   logic [2:0]        c;
   int                rc [8] = '{1024, 512, 256, 128, 64, 32, 16, 13};
   logic [7:0]        adr_t [4] = '{8'h1E, 8'h28, 8'h29, 8'h2A};
   logic [7:0]        rst_t [4] = '{8'h66, 8'h82, 8'h55, 8'h82};

   hpl_top u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_line_strobe(ln_stb), .i_phase_err(ph_err), .o_hlock(o_hlock), .o_hlock_event(o_hlock_event),
      .i_clamp_strobe(cl_stb), .i_clamp_err(cl_err), .o_clamp_ctrl(o_clamp_ctrl), .o_clamp_valid(o_clamp_valid));
   hpl_video_src u_src (.i_mclk(i_mclk), .o_line_strobe(ln_stb), .o_phase_err(ph_err),
      .o_clamp_strobe(cl_stb), .o_clamp_err(cl_err));

   // 25 MHz clock
   always #20 i_mclk = ~i_mclk;

   // ****************************************
   // access and compare tasks
   // ****************************************
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_mclk);
      i_reg_wr = 1'b0;
      @(negedge i_mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_mclk);
      i_reg_rd = 1'b0;
      chk({11'h000, o_reg_rvalid, o_reg_rdata}, {11'h000, 1'b1, exp});
      @(negedge i_mclk);
   endtask
   task automatic lk(input logic exp);
      chk({19'h00000, o_hlock}, {19'h00000, exp});
   endtask
   task automatic end_sim;
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog, about seventeen times the planned run
   initial begin
      #160000;
      errors++;
      end_sim;
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (12) @(negedge i_mclk);
      i_nrst = 1'b1;
      @(negedge i_mclk);
      foreach (adr_t[i]) rd(adr_t[i], rst_t[i]);
      rd(8'h50, 8'h00);
      // default counts: 8 good lines just under 40 samples
      u_src.lines(7, 12'h027, 0);
      lk(1'b0);
      u_src.lines(1, 12'h027, 0);
      lk(1'b1);
      chk({19'h00000, o_hlock_event}, 20'h00001);
      @(negedge i_mclk);
      chk({19'h00000, o_hlock_event}, 20'h00000);
      rd(8'h40, 8'h01);
      // a line equal to the threshold breaks the 32-line bad run
      u_src.lines(31, 12'h029, 2);
      u_src.lines(1, 12'h028, 0);
      u_src.lines(31, 12'h029, 0);
      lk(1'b1);
      u_src.lines(1, 12'h029, 0);
      lk(1'b0);
      // short runs, threshold 8, reserved bits kept as required
      wr(8'h28, 8'h11);
      rd(8'h28, 8'h11);
      wr(8'h29, 8'h51);
      wr(8'h1E, 8'h66);
      wr(8'h40, 8'hFF);
      rd(8'h40, 8'h00);
      u_src.lines(3, 12'h007, 0);
      u_src.lines(1, 12'h008, 0);
      u_src.lines(3, 12'h007, 0);
      lk(1'b0);
      u_src.lines(1, 12'h007, 0);
      lk(1'b1);
      u_src.lines(4, 12'h009, 0);
      lk(1'b0);
      // every gain code, mixed signs so the shifts must floor
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         e = 64 - 40 * i;
         wr(8'h2A, {c[1:0], c[1:0], 1'b0, c});
         acc = acc + e;
         exp_c = (e >>> (6 - c[1:0])) + ((c[1:0] == 2'b11) ? 0 : ((e - prev) >>> c[1:0])) + ((acc * rc[c]) >>> 16);
         prev = e;
         u_src.clamp(e[9:0]);
         chk(o_clamp_ctrl, exp_c[19:0]);
         chk({19'h00000, o_clamp_valid}, 20'h00001);
      end
      // second reset in mid-run restores defaults
      i_nrst = 1'b0;
      @(negedge i_mclk);
      chk(o_clamp_ctrl, 20'h00000);
      repeat (11) @(negedge i_mclk);
      i_nrst = 1'b1;
      @(negedge i_mclk);
      rd(8'h28, 8'h82);
      rd(8'h2A, 8'h82);
      end_sim;
   end
endmodule // hpl_top_test
